// ==== logic/crst_pkg.sv ====
// Constants and types for the core reset and start-up sequencer
package crst_pkg;

  // Reset pin must be seen low this many clock states before acceptance
  localparam logic [3:0] RST_MIN_STATES = 4'ha;

  // Start vector location and reset values of the core registers
  localparam logic [23:0] VEC_BASE = 24'hffff00;
  localparam logic [1:0] VEC_LAST = 2'h2;
  localparam logic [31:0] SP_RESET = 32'h0000_0100;
  localparam logic [2:0] MASK_RESET = 3'h7;
  localparam logic [2:0] BANK_RESET = 3'h0;
  localparam logic WIDE_RESET = 1'b1;
  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;

  // Field positions inside the processor flags word
  localparam int FLAG_BANK_LSB = 8;
  localparam int FLAG_MASK_LSB = 12;
  localparam int FLAG_WIDE_BIT = 15;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_SP = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_SCRATCH = 8'h10;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_VEC, ST_RUN} crst_state_t;

  // Register selector produced by the address decoder
  typedef enum logic [2:0] {
    SEL_STATUS, SEL_PC, SEL_SP, SEL_FLAGS, SEL_SCRATCH, SEL_NONE
  } crst_sel_t;

endpackage

// ==== logic/crst_top.sv ====
// Core reset acceptance, start vector load and reset-time pin control
//
// Functional notes
// [RQ1] The reset source holds the reset pin low for at least ten states.
// [RQ2] The reset source asserts only with stable supply and settled oscillator.
// [RQ3] Program counter loads from vector bytes FFFF00H, FFFF01H, FFFF02H.
// [RQ4] Accepted reset sets the system stack pointer to 100H.
// [RQ5] Accepted reset sets the interrupt mask level to 111.
// [RQ6] Accepted reset sets the wide-address flag; it never clears afterwards.
// [RQ7] Accepted reset clears the register bank pointer to 000.
// [RQ8] After release, fetch starts at the loaded program counter.
// [RQ9] Other core registers keep their value across a pin reset.
// [RQ10] Accepted reset returns peripheral I/O registers to reset values.
// [RQ11] Accepted reset puts every port pin into general-purpose port mode.
// [RQ12] During reset the clock output pin is pulled high.
// [RQ13] During reset the address line 8 port pin is pulled high.
// [RQ14] Outside logic must not drive the pulled-up pins low during reset.
// [RQ15] Outside reset the clock output is the oscillator divided by four.
// [RQ16] Pull-ups on divided clock and clock output apply only during reset.
// [RQ17] Reset pin is sampled on the clock, accepted after ten low states.
// [RQ18] Vector bytes are read in ascending order before the first fetch.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

module crst_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_reset_n_i,
  output logic mem_req_o,
  output logic [23:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  output logic fetch_valid_o,
  output logic [23:0] fetch_addr_o,
  output logic periph_reset_o,
  output logic port_gpio_mode_o,
  output logic clk_out_o,
  output logic clk_out_pullup_o,
  output logic address_line8_pullup_o,
  output logic divided_clock_pullup_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Complete state of the block
  typedef struct packed {
    crst_pkg::crst_state_t st;
    logic [3:0] low_cnt;
    logic [1:0] idx;
    logic [23:0] pc;
    logic [31:0] sp;
    logic [2:0] mask;
    logic wide;
    logic [2:0] bank;
    logic [31:0] scratch;
    logic seen;
    logic [1:0] div;
    logic clk_out;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crst_regs_t;

  crst_regs_t s_reg;
  crst_regs_t s_next;

  // Word-aligned address decoder
  function automatic crst_pkg::crst_sel_t dec(input logic [7:0] a);
    case (a)
      crst_pkg::OFS_STATUS: dec = crst_pkg::SEL_STATUS;
      crst_pkg::OFS_PC: dec = crst_pkg::SEL_PC;
      crst_pkg::OFS_SP: dec = crst_pkg::SEL_SP;
      crst_pkg::OFS_FLAGS: dec = crst_pkg::SEL_FLAGS;
      crst_pkg::OFS_SCRATCH: dec = crst_pkg::SEL_SCRATCH;
      default: dec = crst_pkg::SEL_NONE;
    endcase
  endfunction

  // Merge write data into an old value under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Processor flags word assembled from its fields
  function automatic logic [31:0] flags_word(input logic [2:0] m,
                                             input logic w,
                                             input logic [2:0] bk);
    logic [31:0] f;
    f = 32'h0000_0000;
    f[crst_pkg::FLAG_MASK_LSB +: 3] = m;
    f[crst_pkg::FLAG_WIDE_BIT] = w;
    f[crst_pkg::FLAG_BANK_LSB +: 3] = bk;
    flags_word = f;
  endfunction

  logic pin_low;
  logic accept;
  logic wr_do;
  logic rd_fire;
  logic in_reset;
  crst_pkg::crst_sel_t wsel;
  logic [31:0] fw;

  assign pin_low = !ext_reset_n_i;
  assign in_reset = (s_reg.st == crst_pkg::ST_RESET);
  // Acceptance after the last of the minimum low states [RQ17] [RQ1]
  assign accept = pin_low && !in_reset &&
                  (s_reg.low_cnt == crst_pkg::RST_MIN_STATES - 4'h1);
  assign wr_do = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wsel = dec(s_reg.aw_addr);

  // Next-state logic for sequencer, core registers and bus slave
  always_comb begin
    fw = 32'h0000_0000;
    s_next = s_reg;
    // Low-state counter on the synchronously sampled pin [RQ17]
    if (!pin_low) begin
      s_next.low_cnt = 4'h0;
    end else if (s_reg.low_cnt != crst_pkg::RST_MIN_STATES) begin
      s_next.low_cnt = s_reg.low_cnt + 4'h1;
    end
    // Free-running divider for the clock output [RQ15]
    s_next.div = s_reg.div + 2'h1;

    // Software writes to core registers; SP and flags writes ignored while reset holds the core
    if (wr_do && wsel == crst_pkg::SEL_STATUS && s_reg.w_strb[0] &&
        s_reg.w_data[0]) begin
      s_next.seen = 1'b0;
    end
    if (wr_do && !in_reset && wsel == crst_pkg::SEL_SP) begin
      s_next.sp = merge(s_reg.sp, s_reg.w_data, s_reg.w_strb);
    end
    if (wr_do && !in_reset && wsel == crst_pkg::SEL_FLAGS) begin
      fw = merge(flags_word(s_reg.mask, s_reg.wide, s_reg.bank),
                 s_reg.w_data, s_reg.w_strb);
      s_next.mask = fw[crst_pkg::FLAG_MASK_LSB +: 3];
      s_next.bank = fw[crst_pkg::FLAG_BANK_LSB +: 3];
      // Wide flag ignores writes and stays set [RQ6]
      s_next.wide = crst_pkg::WIDE_RESET;
    end
    // Scratch core register is never touched by a pin reset [RQ9]
    if (wr_do && wsel == crst_pkg::SEL_SCRATCH) begin
      s_next.scratch = merge(s_reg.scratch, s_reg.w_data, s_reg.w_strb);
    end

    // Reset sequencer
    case (s_reg.st)
      crst_pkg::ST_RESET: begin
        if (!pin_low) begin
          s_next.st = crst_pkg::ST_VEC;
          s_next.idx = 2'h0;
        end
      end
      crst_pkg::ST_VEC: begin
        // Vector bytes in ascending order into the program counter [RQ3]
        if (mem_ack_i) begin
          s_next.pc[s_reg.idx*8 +: 8] = mem_rdata_i; // [RQ18]
          s_next.idx = s_reg.idx + 2'h1;
          if (s_reg.idx == crst_pkg::VEC_LAST) begin
            s_next.st = crst_pkg::ST_RUN; // [RQ8]
          end
        end
      end
      crst_pkg::ST_IDLE: begin
        s_next.st = crst_pkg::ST_IDLE;
      end
      crst_pkg::ST_RUN: begin
        s_next.st = crst_pkg::ST_RUN;
      end
      default: begin
        s_next.st = crst_pkg::ST_IDLE;
      end
    endcase

    // Acceptance overrides software writes in the same cycle
    if (accept) begin
      s_next.st = crst_pkg::ST_RESET;
      s_next.sp = crst_pkg::SP_RESET; // [RQ4]
      s_next.mask = crst_pkg::MASK_RESET; // [RQ5]
      s_next.wide = crst_pkg::WIDE_RESET; // [RQ6]
      s_next.bank = crst_pkg::BANK_RESET; // [RQ7]
      s_next.seen = 1'b1; // Set wins over a same-cycle clear
    end

    // Clock output high in reset, else divided by four, phased to match reset
    s_next.clk_out = (s_next.st == crst_pkg::ST_RESET) ?
                     1'b1 : ~^s_next.div; // [RQ12] [RQ15]

    // Write address and data taken independently, response after both
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (wr_do) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = (wsel == crst_pkg::SEL_NONE) ?
                     crst_pkg::RESP_SLVERR : crst_pkg::RESP_OKAY;
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Read channel, one cycle after the address is taken
    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = crst_pkg::RESP_OKAY;
      case (dec(s_axi_araddr))
        crst_pkg::SEL_STATUS:
          s_next.rdata = {28'h0000000, s_reg.st, 1'b0, s_reg.seen};
        crst_pkg::SEL_PC: s_next.rdata = {8'h00, s_reg.pc};
        crst_pkg::SEL_SP: s_next.rdata = s_reg.sp;
        crst_pkg::SEL_FLAGS:
          s_next.rdata = flags_word(s_reg.mask, s_reg.wide, s_reg.bank);
        crst_pkg::SEL_SCRATCH: s_next.rdata = s_reg.scratch;
        default: begin
          s_next.rdata = 32'h0000_0000;
          s_next.rresp = crst_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.st <= crst_pkg::ST_IDLE;
      s_reg.sp <= crst_pkg::SP_RESET;
      s_reg.mask <= crst_pkg::MASK_RESET;
      s_reg.wide <= crst_pkg::WIDE_RESET;
      s_reg.bank <= crst_pkg::BANK_RESET;
      s_reg.scratch <= crst_pkg::SCRATCH_RESET;
      s_reg.clk_out <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Vector read port
  assign mem_req_o = (s_reg.st == crst_pkg::ST_VEC);
  assign mem_addr_o = crst_pkg::VEC_BASE + {22'h0, s_reg.idx}; // [RQ3]
  // Instruction fetch starts only once all vector bytes are in [RQ8]
  assign fetch_valid_o = (s_reg.st == crst_pkg::ST_RUN);
  assign fetch_addr_o = s_reg.pc;
  // Peripheral registers and port modes forced during reset [RQ10] [RQ11]
  assign periph_reset_o = in_reset;
  assign port_gpio_mode_o = in_reset;
  // Pull-ups only while reset is in force [RQ12] [RQ13] [RQ16]
  assign clk_out_pullup_o = in_reset;
  assign address_line8_pullup_o = in_reset;
  assign divided_clock_pullup_o = in_reset;
  assign clk_out_o = s_reg.clk_out;

  // Bus handshake and payload outputs
  assign s_axi_awready = !s_reg.aw_have && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_have && !s_reg.bvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  // Checks on the sequencer behaviour
  a_accept_count: assert property ( // [RQ17]
    @(posedge clk_i) disable iff (!rst_n_i)
    (!in_reset ##1 in_reset) |-> $past(s_reg.low_cnt) == 4'h9 && $past(pin_low)
  ) else $error("Reset accepted without ten low states");

  a_accept_taken: assert property ( // [RQ17]
    @(posedge clk_i) disable iff (!rst_n_i)
    (!in_reset && pin_low) [*8] ##1 (!in_reset && pin_low) ##1 pin_low
    |-> in_reset || $past(s_reg.low_cnt) != 4'h9
  ) else $error("Reset not accepted after ten low states");

  a_sp_loaded: assert property ( // [RQ4]
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(in_reset) |-> s_reg.sp == 32'h0000_0100
  ) else $error("Stack pointer not reset");

  a_mask_loaded: assert property ( // [RQ5]
    @(posedge clk_i) disable iff (!rst_n_i)
    in_reset |-> s_reg.mask == 3'h7
  ) else $error("Interrupt mask not at level seven");

  a_wide_kept: assert property ( // [RQ6]
    @(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |-> s_reg.wide
  ) else $error("Wide address flag cleared");

  a_bank_zero: assert property ( // [RQ7]
    @(posedge clk_i) disable iff (!rst_n_i)
    in_reset |-> s_reg.bank == 3'h0
  ) else $error("Register bank not zero");

  a_vector_byte: assert property ( // [RQ3]
    @(posedge clk_i) disable iff (!rst_n_i)
    (mem_req_o && mem_ack_i && !accept)
    |-> mem_addr_o == 24'hffff00 + {22'h0, s_reg.idx}
    ##1 s_reg.pc[$past(s_reg.idx)*8 +: 8] == $past(mem_rdata_i)
  ) else $error("Vector byte not loaded");

  a_fetch_after: assert property ( // [RQ8] [RQ18]
    @(posedge clk_i) disable iff (!rst_n_i)
    (mem_req_o && mem_ack_i && s_reg.idx == 2'h2 && !accept)
    |=> fetch_valid_o && fetch_addr_o[23:16] == $past(mem_rdata_i)
  ) else $error("Fetch not started after vector");

  a_pullups: assert property ( // [RQ12] [RQ13] [RQ16]
    @(posedge clk_i) disable iff (!rst_n_i)
    clk_out_pullup_o == in_reset && address_line8_pullup_o == in_reset &&
    divided_clock_pullup_o == in_reset && (!in_reset || clk_out_o)
  ) else $error("Pull-up or clock level wrong");

  a_clk_divide: assert property ( // [RQ15]
    @(posedge clk_i) disable iff (!rst_n_i)
    (!in_reset) [*3] |-> clk_out_o != $past(clk_out_o, 2)
  ) else $error("Clock output not divided by four");

  a_scratch_kept: assert property ( // [RQ9]
    @(posedge clk_i) disable iff (!rst_n_i)
    ($rose(in_reset) && !$past(wr_do)) |-> $stable(s_reg.scratch)
  ) else $error("Core register changed by reset");

  a_periph_reset: assert property ( // [RQ10] [RQ11]
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(in_reset) |-> periph_reset_o && port_gpio_mode_o
  ) else $error("Peripherals not reset");

endmodule // crst_top

// ==== test/crst_supervisor.sv ====
// Reset supervisor and start vector memory model facing the sequencer
`timescale 1ns/1ps

module crst_supervisor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic [7:0] low_len_i,
  input wire logic supply_ok_i,
  input wire logic slow_i,
  input wire logic [23:0] vec_i,
  input wire logic mem_req_i,
  input wire logic [23:0] mem_addr_i,
  output logic ext_reset_n_o,
  output logic busy_o,
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] cnt_reg;
  logic [1:0] dly_reg;
  logic [7:0] byte_sel;

  // Vector byte chosen by the low address bits
  always_comb begin
    case (mem_addr_i[1:0])
      2'h0: byte_sel = vec_i[7:0];
      2'h1: byte_sel = vec_i[15:8];
      default: byte_sel = vec_i[23:16];
    endcase
  end

  assign busy_o = (cnt_reg != 8'h00);

  // Pulse timing and slow or prompt memory answers
  // Pulled-up pins are never driven from this side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_reset_n_o <= 1'b1;
      cnt_reg <= 8'h00;
      dly_reg <= 2'h0;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 8'h00;
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o; // Idle data keeps changing
      if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) ext_reset_n_o <= 1'b1;
      end else if (go_i && supply_ok_i) begin
        ext_reset_n_o <= 1'b0;
        cnt_reg <= low_len_i;
      end
      if (mem_req_i && !mem_ack_o) begin
        if (dly_reg >= {slow_i, slow_i}) begin
          mem_ack_o <= 1'b1;
          mem_rdata_o <= byte_sel;
          dly_reg <= 2'h0;
        end else begin
          dly_reg <= dly_reg + 2'h1;
        end
      end
    end
  end
endmodule // crst_supervisor

// ==== test/tb_top.sv ====
// Self-checking bench for the core reset and start-up sequencer
`timescale 1ns/1ps

module tb_top;
  typedef struct packed {
    logic [7:0] len;
    logic slow;
    logic [23:0] vec;
    logic [23:0] exp_pc;
  } crst_row_t;
  localparam logic [31:0] FL_MASK = 32'h0000_f700;

  logic clk_i, rst_n_i, ext_reset_n_i, mem_ack_i, mem_req_o, fetch_valid_o;
  logic periph_reset_o, port_gpio_mode_o, clk_out_o, clk_out_pullup_o;
  logic address_line8_pullup_o, divided_clock_pullup_o, go, slow, busy;
  logic [7:0] mem_rdata_i, s_axi_awaddr, s_axi_araddr, len, q;
  logic [23:0] mem_addr_o, fetch_addr_o, vec;
  logic [23:0] vaddr [0:3];
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int err_count, n_tests, vn;
  crst_row_t rows [0:3];

  crst_top dut (.clk_i, .rst_n_i, .ext_reset_n_i, .mem_req_o, .mem_addr_o,
    .mem_ack_i, .mem_rdata_i, .fetch_valid_o, .fetch_addr_o, .periph_reset_o,
    .port_gpio_mode_o, .clk_out_o, .clk_out_pullup_o, .address_line8_pullup_o,
    .divided_clock_pullup_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  crst_supervisor sup (.clk_i, .rst_n_i, .go_i(go), .low_len_i(len),
    .supply_ok_i(1'b1), .slow_i(slow), .vec_i(vec), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .ext_reset_n_o(ext_reset_n_i), .busy_o(busy),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  // Clock at 8 ns period
  always #4 clk_i = ~clk_i;

  // Record each vector byte address as it is handed over
  always @(negedge clk_i) begin
    if (mem_req_o && mem_ack_i && vn < 4) begin
      vaddr[vn] = mem_addr_o;
      vn++;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task close_out();
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Write cycle: address and data offered together, released when taken
  task axw(input logic [7:0] a, input logic [31:0] wd);
    logic ta, tw;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
    do @(negedge clk_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
  endtask

  task axr(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_i); while (!s_axi_arready);
    @(posedge clk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
  endtask

  // One pin pulse, then the vector load and the start of fetching
  task pin_reset(input crst_row_t w);
    int n;
    n = 0;
    vn = 0;
    @(posedge clk_i);
    vec <= w.vec;
    slow <= w.slow;
    len <= w.len;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do @(negedge clk_i); while (busy);
    if (w.len >= 8'd10)
      chk(32'({clk_out_pullup_o, address_line8_pullup_o, divided_clock_pullup_o,
        clk_out_o, periph_reset_o, port_gpio_mode_o, fetch_valid_o}),
        32'h7e);
    while (fetch_valid_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk(32'(fetch_addr_o), 32'(w.exp_pc));
    chk(32'({clk_out_pullup_o, address_line8_pullup_o, divided_clock_pullup_o,
      periph_reset_o, port_gpio_mode_o, mem_req_o, fetch_valid_o}),
      32'h1);
    chk(32'(vn), (w.len >= 8'd10) ? 32'h3 : 32'h0);
    if (vn == 3)
      for (int j = 0; j < 3; j++)
        chk(32'(vaddr[j]), 32'(crst_pkg::VEC_BASE) + 32'(j));
  endtask

  // Main sequence
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    {go, slow, len, vec, err_count, n_tests, vn} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    rows[0] = '{8'd10, 1'b0, 24'h123456, 24'h123456};
    rows[1] = '{8'd25, 1'b1, 24'hfedcba, 24'hfedcba};
    rows[2] = '{8'd12, 1'b1, 24'h000000, 24'h000000};
    rows[3] = '{8'd10, 1'b0, 24'hffffff, 24'hffffff};
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk(32'({fetch_valid_o, mem_req_o, clk_out_o}), 32'h1);
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++)
      pin_reset(rows[i]);
    axr(crst_pkg::OFS_STATUS);
    chk(d & 32'hd, 32'hd);
    axw(crst_pkg::OFS_SP, 32'h0000_55aa);
    axw(crst_pkg::OFS_FLAGS, 32'h0000_2500);
    axw(crst_pkg::OFS_SCRATCH, 32'hcafe_1234);
    axw(crst_pkg::OFS_PC, 32'h0);
    chk(32'(r), 32'(crst_pkg::RESP_OKAY));
    axr(crst_pkg::OFS_PC);
    chk(d, 32'(rows[3].exp_pc));
    axr(crst_pkg::OFS_FLAGS);
    chk(d & FL_MASK, 32'h0000_a500);
    axr(8'h20);
    chk({d[29:0], r}, {30'h0, crst_pkg::RESP_SLVERR});
    axw(8'h20, 32'h1);
    chk(32'(r), 32'(crst_pkg::RESP_SLVERR));
    axw(crst_pkg::OFS_STATUS, 32'h1);
    pin_reset('{8'd9, 1'b0, 24'h0, rows[3].exp_pc});
    axr(crst_pkg::OFS_STATUS);
    chk(d & 32'h1, 32'h0);
    pin_reset('{8'd10, 1'b1, 24'habcdef, 24'habcdef});
    axr(crst_pkg::OFS_SP);
    chk(d, 32'h0000_0100);
    axr(crst_pkg::OFS_FLAGS);
    chk(d & FL_MASK, 32'h0000_f000);
    axr(crst_pkg::OFS_SCRATCH);
    chk(d, 32'hcafe_1234);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      q[i] = clk_out_o;
    end
    chk(32'(q[5:0] ^ q[7:2]), 32'h3f);
    // Mid-run bus reset: back to idle, scratch cleared, byte strobes honoured
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk(32'({fetch_valid_o, mem_req_o, clk_out_o, clk_out_pullup_o}), 32'h2);
    axr(crst_pkg::OFS_STATUS);
    chk(d, 32'h0);
    axr(crst_pkg::OFS_SCRATCH);
    chk(d, 32'(crst_pkg::SCRATCH_RESET));
    s_axi_wstrb <= 4'h6;
    axw(crst_pkg::OFS_SCRATCH, 32'h1122_3344);
    s_axi_wstrb <= 4'hf;
    axr(crst_pkg::OFS_SCRATCH);
    chk(d, (32'(crst_pkg::SCRATCH_RESET) & 32'hff00_00ff) | 32'h0022_3300);
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    close_out();
  end
endmodule // tb_top
